// ==== logic/skey_key.sv ====
// key end of the three-wire link: command decode, id readout, match, memory
// assumes enable, clock and data arrive unsynchronised from the host
//
// How it works
// - enable high, then 24 command bits shift in
// - invalid normal command ignores the transfer
// - valid normal command: 64 id bits out
// - host then writes 64 compare bits
// - mismatch on read: 128 random bits out
// - mismatch on write: writes discarded
// - match grants 128-bit user memory access
// - program mode stores 128 bits: id, match
// - bad program command ignores the transfer
// - first byte read or write pattern only
// - byte two bits 1:0 pick mode
// - program needs the write pattern
// - thirteen-bit device code must match exactly
// - last command bit must be one
// - enable low ends transfer, releases data
// - sample on rise, drive after fall
// - rising clock edge releases data line
// - host drops enable while clock high
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module skey_key #(
    parameter logic [skey_pkg::DEV_W-1:0] DEV_CODE = 13'h0a5a,
    parameter logic [63:0] ID_INIT = 64'h0123_4567_89ab_cdef,
    parameter logic [63:0] MATCH_INIT = 64'h0f1e_2d3c_4b5a_6978
)(
    input wire logic i_core_clk,
    input wire logic i_srst,
    skey_if.key link,
    output logic o_active,
    output logic o_granted
);
    import skey_pkg::*;

    typedef enum logic [2:0] {
        SK_IDLE = 3'b000,
        SK_CMD = 3'b001,
        SK_ID = 3'b010,
        SK_CMP = 3'b011,
        SK_MEM = 3'b100,
        SK_PROG = 3'b101,
        SK_HALT = 3'b110
    } skey_state_t;

    ////////////////////////////////////////////////////////////////
    // pin filters: three flops, change taken once stages two and three agree

    logic [2:0] en_s;
    logic [2:0] clk_s;
    logic [2:0] dq_s;
    logic en_f;
    logic clk_f;
    logic dq_f;
    logic clk_d;

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            en_s <= 3'h0;
            clk_s <= 3'h0;
            dq_s <= 3'h0;
            en_f <= 1'b0;
            clk_f <= 1'b0;
            dq_f <= 1'b0;
            clk_d <= 1'b0;
        end
        else
        begin
            en_s <= {en_s[1:0], link.en};
            clk_s <= {clk_s[1:0], link.sclk};
            dq_s <= {dq_s[1:0], link.dq_line};
            if (en_s[2] == en_s[1])
                en_f <= en_s[2];
            if (clk_s[2] == clk_s[1])
                clk_f <= clk_s[2];
            if (dq_s[2] == dq_s[1])
                dq_f <= dq_s[2];
            clk_d <= clk_f;
        end
    end

    wire clk_rise = clk_f & ~clk_d;
    wire clk_fall = ~clk_f & clk_d;

    ////////////////////////////////////////////////////////////////
    // state

    skey_state_t state;
    logic [7:0] cnt;
    logic [23:0] cmd;
    logic [63:0] cmp;
    logic [63:0] id_mem;
    logic [63:0] match_mem;
    logic [127:0] user_mem;
    logic is_wr;
    logic dq_o;
    logic oe_n;
    logic [15:0] lfsr;

    ////////////////////////////////////////////////////////////////
    // command decode, done on the word as it will stand after this bit

    wire [23:0] next_cmd = {dq_f, cmd[23:1]};
    wire [63:0] next_cmp = {dq_f, cmp[63:1]};
    wire pat_rd = next_cmd[7:0] == PAT_READ;
    wire pat_wr = next_cmd[7:0] == PAT_WRITE;
    wire mode_norm = next_cmd[9:8] == MODE_NORM;
    wire mode_prog = next_cmd[9:8] == MODE_PROG;
    wire dev_ok = next_cmd[22:10] == DEV_CODE;
    wire tail_ok = next_cmd[23];
    wire hdr_ok = dev_ok & tail_ok;
    wire norm_ok = hdr_ok & mode_norm & (pat_rd | pat_wr);
    wire prog_ok = hdr_ok & mode_prog & pat_wr;

    wire cmd_last = cnt == 8'(CMD_BITS - 1);
    wire id_last = cnt == 8'(ID_BITS - 1);
    wire mem_last = cnt == 8'(MEM_BITS - 1);
    wire cmp_hit = next_cmp == match_mem;

    // data is driven only in read phases; the key never contends on writes
    wire drive_now = (state == SK_ID) | ((state == SK_MEM) & ~is_wr);
    wire mem_bit = o_granted ? user_mem[cnt[6:0]] : lfsr[0];
    wire out_bit = (state == SK_ID) ? id_mem[cnt[5:0]] : mem_bit;

    ////////////////////////////////////////////////////////////////
    // random source, free running so its phase is not tied to the link

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
            lfsr <= LFSR_SEED;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    ////////////////////////////////////////////////////////////////
    // transfer sequencer

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            state <= SK_IDLE;
            cnt <= 8'h00;
            cmd <= 24'h000000;
            cmp <= 64'h0;
            id_mem <= ID_INIT;
            match_mem <= MATCH_INIT;
            user_mem <= 128'h0;
            is_wr <= 1'b0;
            dq_o <= 1'b0;
            oe_n <= 1'b1;
            o_granted <= 1'b0;
            o_active <= 1'b0;
        end
        else
        begin
            o_active <= en_f;
            if (!en_f)
            begin
                state <= SK_IDLE;
                cnt <= 8'h00;
                oe_n <= 1'b1;
                o_granted <= 1'b0;
            end
            else if (clk_rise)
            begin
                oe_n <= 1'b1;
                cnt <= cnt + 8'h01;
                unique case (state)
                    SK_IDLE, SK_CMD:
                    begin
                        cmd <= next_cmd;
                        state <= SK_CMD;
                        if (cmd_last)
                        begin
                            cnt <= 8'h00;
                            is_wr <= pat_wr;
                            if (prog_ok)
                                state <= SK_PROG;
                            else if (norm_ok)
                                state <= SK_ID;
                            else
                                state <= SK_HALT;
                        end
                    end
                    SK_ID:
                    begin
                        if (id_last)
                        begin
                            cnt <= 8'h00;
                            state <= SK_CMP;
                        end
                    end
                    SK_CMP:
                    begin
                        cmp <= next_cmp;
                        if (id_last)
                        begin
                            cnt <= 8'h00;
                            o_granted <= cmp_hit;
                            state <= SK_MEM;
                        end
                    end
                    SK_MEM:
                    begin
                        if (is_wr & o_granted)
                            user_mem[cnt[6:0]] <= dq_f;
                        if (mem_last)
                            state <= SK_HALT;
                    end
                    SK_PROG:
                    begin
                        if (cnt[6])
                            match_mem[cnt[5:0]] <= dq_f;
                        else
                            id_mem[cnt[5:0]] <= dq_f;
                        if (mem_last)
                            state <= SK_HALT;
                    end
                    SK_HALT:
                    begin
                        cnt <= cnt;
                    end
                endcase
            end
            else if (clk_fall && drive_now)
            begin
                oe_n <= 1'b0;
                dq_o <= out_bit;
            end
            else if (state == SK_IDLE)
            begin
                cnt <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // pins

    assign link.key_dq = dq_o;
    assign link.key_oe_n = oe_n;

endmodule // skey_key

// ==== inc/skey_pkg.sv ====
// constants shared by both ends of the three-wire key link
// assumes a 125 MHz core clock on each end
package skey_pkg;
    localparam int CMD_BITS = 24;
    localparam int ID_BITS = 64;
    localparam int MEM_BITS = 128;
    localparam int DEV_W = 13;
    localparam logic [7:0] PAT_READ = 8'h62;
    localparam logic [7:0] PAT_WRITE = 8'h9d;
    localparam logic [1:0] MODE_NORM = 2'h1;
    localparam logic [1:0] MODE_PROG = 2'h2;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    // bit positions in the full transfer, counted from the first command bit
    localparam logic [8:0] POS_CMP = 9'h058;
    localparam logic [8:0] POS_MEM = 9'h098;
    localparam logic [8:0] LEN_PROG = 9'h098;
    localparam logic [8:0] LEN_NORM = 9'h118;
    // host register indices
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_DEVSEL = 5'h01;
    localparam logic [4:0] REG_TX = 5'h08;
    localparam logic [4:0] REG_RX = 5'h10;
    localparam int BUF_WORDS = 6;
    // link timing
    localparam int CORE_NS = 8;
    localparam int CLK_HALF_NS = 125;
    localparam int EN_SETUP_NS = 1000;
    localparam int EN_IDLE_NS = 125;
    localparam int HALF_CYC = (CLK_HALF_NS + CORE_NS - 1) / CORE_NS;
    localparam int SETUP_CYC = (EN_SETUP_NS + CORE_NS - 1) / CORE_NS;
    localparam int IDLE_CYC = (EN_IDLE_NS + CORE_NS - 1) / CORE_NS;
    localparam logic [10:0] RESET_TMR = 11'h000;
endpackage

// ==== inc/skey_if.sv ====
// three-wire link between host and key: enable, serial clock, shared data
// the shared data wire is resolved here; an undriven wire reads low
`timescale 1ns/100ps
interface skey_if;
    logic en;
    logic sclk;
    logic host_dq;
    logic host_oe_n;
    logic key_dq;
    logic key_oe_n;
    wire dq_line;

    assign dq_line = !host_oe_n ? host_dq : (!key_oe_n ? key_dq : 1'b0);

    modport key (input en, input sclk, input dq_line, output key_dq, output key_oe_n);
    modport host (output en, output sclk, output host_dq, output host_oe_n, input dq_line);
endinterface // skey_if

// ==== logic/skey_host.sv ====
// host end of the three-wire link: makes enable and serial clock, moves bits
// assumes a plain register port on the core side, read data one cycle late
`timescale 1ns/100ps
module skey_host #(
    parameter int HALF = skey_pkg::HALF_CYC,
    parameter int SETUP = skey_pkg::SETUP_CYC,
    parameter int GAP = skey_pkg::IDLE_CYC
)(
    input wire logic i_core_clk,
    input wire logic i_srst,
    skey_if.host link,
    input wire logic [4:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);
    import skey_pkg::*;

    // key data reaches dq_f about nine clocks after the fall; sampled at end of low half
    if (HALF < 10 || HALF > 2047 || SETUP < 1 || SETUP > 2047 || GAP < 1 || GAP > 2047)
    begin : g_bad_timing
        $error("skey_host: timing parameter out of range");
    end

    typedef enum logic [2:0] {
        SH_IDLE = 3'b000,
        SH_SETUP = 3'b001,
        SH_LOW = 3'b010,
        SH_HIGH = 3'b011,
        SH_GAP = 3'b100
    } skey_hstate_t;

    skey_hstate_t state;
    logic [10:0] tmr;
    logic [8:0] idx;
    logic is_wr;
    logic is_prog;
    logic done;
    logic [12:0] devsel;
    logic [191:0] tx;
    logic [191:0] rx;
    logic [2:0] dq_s;
    logic dq_f;

    ////////////////////////////////////////////////////////////////
    // bit decode for the current position

    wire [7:0] pat = is_wr ? PAT_WRITE : PAT_READ;
    wire [1:0] mode = is_prog ? MODE_PROG : MODE_NORM;
    wire [23:0] cmd = {1'b1, devsel, mode, pat};
    wire in_cmd = idx < 9'(CMD_BITS);
    wire sends = in_cmd | is_prog | ((idx >= POS_CMP) & ((idx < POS_MEM) | is_wr));
    wire [8:0] tx_off = is_prog ? 9'(CMD_BITS) : POS_CMP;
    wire [8:0] tx_pos = idx - tx_off;
    wire [8:0] rx_pos = (idx < POS_CMP) ? idx - 9'(CMD_BITS) : idx - POS_CMP;
    wire tx_bit = in_cmd ? cmd[idx[4:0]] : tx[tx_pos[7:0]];
    wire [8:0] nbits = is_prog ? LEN_PROG : LEN_NORM;
    wire tmr_end = tmr == RESET_TMR;
    wire start = i_wr & (i_addr == REG_CTRL) & i_wdata[0] & (state == SH_IDLE);
    wire [4:0] tx_word = i_addr - REG_TX;
    wire [4:0] rx_word = i_addr - REG_RX;
    wire tx_hit = (i_addr >= REG_TX) & (tx_word < 5'(BUF_WORDS));
    wire rx_hit = (i_addr >= REG_RX) & (rx_word < 5'(BUF_WORDS));

    ////////////////////////////////////////////////////////////////
    // register port

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_rdata <= 32'h0;
            devsel <= 13'h0;
            tx <= 192'h0;
            is_wr <= 1'b0;
            is_prog <= 1'b0;
        end
        else
        begin
            o_rdata <= 32'h0;
            if (i_rd && i_addr == REG_CTRL)
                o_rdata <= {27'h0, is_prog, is_wr, done, 1'b0, state != SH_IDLE};
            else if (i_rd && i_addr == REG_DEVSEL)
                o_rdata <= {19'h0, devsel};
            else if (i_rd && tx_hit)
                o_rdata <= tx[tx_word[2:0] * 32 +: 32];
            else if (i_rd && rx_hit)
                o_rdata <= rx[rx_word[2:0] * 32 +: 32];
            if (start)
            begin
                is_wr <= i_wdata[1] | i_wdata[2];
                is_prog <= i_wdata[2];
            end
            if (i_wr && i_addr == REG_DEVSEL && state == SH_IDLE)
                devsel <= i_wdata[12:0];
            if (i_wr && tx_hit && state == SH_IDLE)
                tx[tx_word[2:0] * 32 +: 32] <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // link sequencer; clock rests high so enable always falls with it high

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            state <= SH_IDLE;
            tmr <= RESET_TMR;
            idx <= 9'h000;
            done <= 1'b0;
            rx <= 192'h0;
            dq_s <= 3'h0;
            dq_f <= 1'b0;
            link.en <= 1'b0;
            link.sclk <= 1'b1;
            link.host_dq <= 1'b0;
            link.host_oe_n <= 1'b1;
        end
        else
        begin
            dq_s <= {dq_s[1:0], link.dq_line};
            if (dq_s[2] == dq_s[1])
                dq_f <= dq_s[2];
            if (!tmr_end)
                tmr <= tmr - 11'h001;
            unique case (state)
                SH_IDLE:
                begin
                    if (start)
                    begin
                        done <= 1'b0;
                        idx <= 9'h000;
                        link.en <= 1'b1;
                        tmr <= 11'(SETUP - 1);
                        state <= SH_SETUP;
                    end
                end
                SH_SETUP, SH_HIGH:
                begin
                    if (tmr_end && idx == nbits)
                    begin
                        link.en <= 1'b0;
                        link.host_oe_n <= 1'b1;
                        tmr <= 11'(GAP - 1);
                        state <= SH_GAP;
                    end
                    else if (tmr_end)
                    begin
                        link.sclk <= 1'b0;
                        link.host_oe_n <= ~sends;
                        link.host_dq <= sends & tx_bit;
                        tmr <= 11'(HALF - 1);
                        state <= SH_LOW;
                    end
                end
                SH_LOW:
                begin
                    if (tmr_end)
                    begin
                        link.sclk <= 1'b1;
                        if (!sends)
                            rx[rx_pos[7:0]] <= dq_f;
                        idx <= idx + 9'h001;
                        tmr <= 11'(HALF - 1);
                        state <= SH_HIGH;
                    end
                end
                SH_GAP:
                begin
                    if (tmr_end)
                    begin
                        done <= 1'b1;
                        state <= SH_IDLE;
                    end
                end
            endcase
        end
    end

endmodule // skey_host

// ==== bench/skey_properties.sv ====
// link assertions between the host and key ends
// assumes one core clock and a synchronous reset for both ends
`timescale 1ns/100ps
module skey_properties (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic en,
    input wire logic sclk,
    input wire logic host_dq,
    input wire logic host_oe_n,
    input wire logic key_dq,
    input wire logic key_oe_n,
    input wire logic dq_line
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // rises seen in this transfer; sets where the key may drive
    logic [8:0] rises;
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst || !en)
            rises <= 9'h000;
        else if ($rose(sclk))
            rises <= rises + 9'h001;
    end
    ////////////////////////////////////////////////////////////////
    a_rest_idle: assert property (!en [*2] |-> sclk && host_oe_n)
        else $error("link not idle with enable low");
    a_release_idle: assert property ($fell(en) |-> ##[0:8] key_oe_n)
        else $error("key holds data after enable drop");
    // filter delay in the key, hence the slack
    a_release_rise: assert property ($rose(sclk) |-> ##[0:10] key_oe_n)
        else $error("key holds data after clock rise");
    a_no_fight: assert property (!(!host_oe_n && !key_oe_n))
        else $error("both ends drive data");
    a_drive_low: assert property ($fell(key_oe_n) |-> !sclk)
        else $error("key starts driving with clock high");
    a_stop_high: assert property ($fell(en) |-> sclk && $past(sclk))
        else $error("enable dropped with clock low");
    a_setup_wait: assert property ($rose(en) |-> sclk [*8])
        else $error("clock fell too soon after enable");
    a_host_stable: assert property ($rose(sclk) && !host_oe_n |-> $stable(host_dq))
        else $error("host data moved at clock rise");
    a_drive_window: assert property (!key_oe_n |->
        (rises >= 9'h018 && rises <= 9'h058) || rises >= 9'h098)
        else $error("key drove outside its read fields");
    a_key_hold: assert property (!key_oe_n && !$past(key_oe_n) |->
        $stable(key_dq) && dq_line == key_dq)
        else $error("key data moved while driving");
endmodule // skey_properties

// ==== bench/skey_bench.sv ====
// bench: host and key joined on one link; a bit-banged second link
// assumes the host register map and bit positions of the hand-over
`timescale 1ns/100ps
module skey_bench;
    import skey_pkg::*;
    localparam logic [12:0] DEV = 13'h0a5a;
    localparam logic [63:0] ID0 = 64'h1122_3344_5566_7788;
    localparam logic [63:0] MT0 = 64'h99aa_bbcc_ddee_f001;
    localparam logic [63:0] ID1 = 64'h0f0f_1234_a5a5_c3c3;
    localparam logic [63:0] MT1 = 64'h7e57_0bad_cafe_0001;
    localparam logic [127:0] MEMA = 128'hdead_beef_0123_4567_89ab_cdef_fedc_ba98;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [4:0] i_addr = 5'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic gnt_a;
    logic act_b;
    logic gnt_b;
    logic gseen;
    int fails = 0;
    int cmp_count = 0;
    skey_if link();
    skey_if s2();
    always #4 i_core_clk = ~i_core_clk;
    // short setup and half period keep the run small
    skey_host #(.HALF(12), .SETUP(8), .GAP(4)) u_skey_host (.i_core_clk(i_core_clk),
        .i_srst(i_srst), .link(link.host), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    skey_key #(.DEV_CODE(DEV), .ID_INIT(ID0), .MATCH_INIT(MT0)) u_skey_key (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .link(link.key), .o_active(),
        .o_granted(gnt_a));
    skey_key #(.DEV_CODE(DEV), .ID_INIT(ID0), .MATCH_INIT(MT0)) u_skey_key_b (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .link(s2.key), .o_active(act_b),
        .o_granted(gnt_b));
    skey_properties u_skey_properties (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .en(link.en), .sclk(link.sclk), .host_dq(link.host_dq),
        .host_oe_n(link.host_oe_n), .key_dq(link.key_dq), .key_oe_n(link.key_oe_n),
        .dq_line(link.dq_line));
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic xfer(input logic [2:0] ctl, input logic [191:0] tx,
        output logic [191:0] rx);
        logic [31:0] d;
        int n;
        for (int k = 0; k < 6; k++)
            wr(REG_TX + 5'(k), tx[32*k +: 32]);
        wr(REG_CTRL, {29'h0, ctl | 3'h1});
        n = 0;
        d = 32'h0;
        gseen = 1'b0;
        while (d[2] !== 1'b1 && n < 5000)
        begin
            rd(REG_CTRL, d);
            gseen = gseen | gnt_a;
            n++;
        end
        if (d[2] !== 1'b1)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, d, 32'h4);
            test_done();
        end
        for (int k = 0; k < 6; k++)
        begin
            rd(REG_RX + 5'(k), d);
            rx[32*k +: 32] = d;
        end
    endtask
    // stops after the id field: also shows an early enable drop is harmless
    task automatic bang(input logic [23:0] c, output logic drove, output logic [63:0] got);
        drove = 1'b0;
        s2.en <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        for (int i = 0; i < 88; i++)
        begin
            s2.sclk <= 1'b0;
            s2.host_oe_n <= (i >= 24);
            s2.host_dq <= c[i % 24];
            repeat (8) @(posedge i_core_clk);
            if (i >= 24)
            begin
                got[i - 24] = s2.dq_line;
                drove = drove | !s2.key_oe_n;
            end
            s2.sclk <= 1'b1;
            repeat (8) @(posedge i_core_clk);
        end
        chk({act_b, gnt_b}, 2'h2);
        s2.en <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        chk(act_b, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [191:0] rx;
        logic [31:0] d;
        logic drove;
        logic [63:0] got;
        logic [23:0] bad [7];
        s2.en = 1'b0;
        s2.sclk = 1'b1;
        s2.host_oe_n = 1'b1;
        s2.host_dq = 1'b0;
        repeat (12) @(posedge i_core_clk);
        i_srst <= 1'b0;
        wr(REG_DEVSEL, {19'h0, DEV});
        rd(5'h1f, d);
        chk(d, 0);
        xfer(3'h0, {128'h0, ~MT0}, rx);
        chk(rx[63:0], ID0);
        chk(rx[191:64] === 128'h0, 1'b0);
        chk(gseen, 1'b0);
        $display("test read mismatch done");
        xfer(3'h4, {64'h0, MT1, ID1}, rx);
        rd(REG_CTRL, d);
        chk(d, 32'h1c);
        xfer(3'h0, {128'h0, MT1}, rx);
        chk(rx, {128'h0, ID1});
        chk(gseen, 1'b1);
        $display("test program done");
        xfer(3'h2, {MEMA, ~MT1}, rx);
        chk(gseen, 1'b0);
        xfer(3'h0, {128'h0, MT1}, rx);
        chk(rx[191:64], 128'h0);
        $display("test write mismatch done");
        xfer(3'h2, {MEMA, MT1}, rx);
        chk(gseen, 1'b1);
        xfer(3'h0, {128'h0, MT1}, rx);
        chk(rx, {MEMA, ID1});
        $display("test write match done");
        bad[0] = {1'b1, DEV, MODE_NORM, 8'h63};
        bad[1] = {1'b1, DEV, 2'h0, PAT_READ};
        bad[2] = {1'b1, DEV, 2'h3, PAT_WRITE};
        bad[3] = {1'b1, DEV, MODE_PROG, PAT_READ};
        bad[4] = {1'b1, DEV ^ 13'h1000, MODE_NORM, PAT_READ};
        bad[5] = {1'b0, DEV, MODE_NORM, PAT_WRITE};
        bad[6] = {1'b1, DEV ^ 13'h0001, MODE_PROG, PAT_WRITE};
        for (int j = 0; j < 7; j++)
        begin
            bang(bad[j], drove, got);
            chk(drove, 1'b0);
        end
        bang({1'b1, DEV, MODE_NORM, PAT_WRITE}, drove, got);
        chk({drove, got}, {1'b1, ID0});
        $display("test command decode done");
        rd(REG_DEVSEL, d);
        chk(d, {19'h0, DEV});
        rd(REG_TX + 5'h1, d);
        chk(d, MT1[63:32]);
        $display("test readback done");
        test_done();
    end
endmodule // skey_bench
